// ### rtl/msw_pkg.sv
// constants, types and register map of the multi-segment playback controller
package msw_pkg;
  // ***************************************************************
  // sizes and timing
  // ***************************************************************
  localparam int SEG_W  = 2;
  localparam int NSEG   = 4;
  localparam int OFS_W  = 6;
  localparam int MEM_D  = 64;
  localparam int SMP_W  = 16;
  localparam int WORD_W = 18;
  localparam int FIFO_D = 4;
  localparam int CLK_NS = 100;
  localparam int GAP_NS = 400;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] GAP_LOAD = 3'(GAP_CYC - 1);
  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_SEL   = 8'h04;
  localparam logic [7:0] REG_TRIG  = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_WADDR = 8'h10;
  localparam logic [7:0] REG_WDATA = 8'h14;
  localparam logic [3:0] PAGE_SEG  = 4'h2;
  localparam logic [3:0] PAGE_LIST = 4'h3;
  localparam int CTRL_W = 9;
  localparam int CTRL_EN = 0;
  localparam int CTRL_NM = 1;
  localparam int CTRL_TM = 3;
  localparam int CTRL_EXT = 6;
  localparam int CTRL_RSTMK = 7;
  localparam int CTRL_IGNMK = 8;
  localparam int TRIG_FIRE = 0;
  localparam int SEGT_W = 14;
  localparam int SEG_LAST = 8;
  localparam int LIST_W = 10;
  localparam int LST_REP = 4;
  localparam int LST_NXT = 8;
  localparam int MK1 = 16;
  localparam int MK2 = 17;
  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {NM_SAME, NM_NEXT, NM_SEQ, NM_SEAMLESS} msw_nmode_t;
  typedef enum logic [2:0] {TM_AUTO, TM_ARMED_AUTO, TM_RETRIG, TM_ARMED_RETRIG, TM_SINGLE} msw_tmode_t;
  typedef enum logic [1:0] {ST_HALT, ST_GAP, ST_PLAY} msw_st_t;
  typedef struct packed {
    logic [CTRL_W-1:0]              ctrl;
    logic [SEG_W-1:0]               sel;
    logic [SEG_W-1:0]               applied;
    logic [SEG_W-1:0]               cur;
    logic [SEG_W-1:0]               seq_idx;
    logic [NSEG-1:0][SEGT_W-1:0]    segt;
    logic [NSEG-1:0][LIST_W-1:0]    list;
    logic [MEM_D-1:0][WORD_W-1:0]   wave;
    logic [OFS_W-1:0]               waddr;
    logic [OFS_W-1:0]               ofs;
    msw_st_t                        st;
    logic [2:0]                     gap_cnt;
    logic [3:0]                     reps;
    logic                           once;
    logic                           first;
    logic                           pend_trig;
    logic                           pend_next;
    logic                           pready;
    logic                           pslverr;
    logic [2:0]                     trig_sync;
    logic [2:0]                     next_sync;
    logic [31:0]                    prdata;
    logic                           out_valid;
    logic [WORD_W-1:0]              out_word;
  } msw_regs_t;
  localparam msw_regs_t REGS_RST = '0;
endpackage

// ### rtl/msw_play.sv
// multi-segment playback controller with apb registers and sample fifo
//
// Functional notes
// - same segment, auto: start at once, loop forever, ignore triggers.
// - auto and retrigger: segment change stops output, new one follows after gap.
// - same segment, armed auto: wait first trigger, loop, ignore later triggers.
// - armed settings: segment change halts output until a trigger arrives.
// - retrigger: loop at once, each trigger restarts from first sample.
// - armed retrigger: wait first trigger, loop, restart on later triggers.
// - single: each trigger plays the segment once from start, then stop.
// - single: segment change does not interrupt; new segment on next trigger.
// - next segment mode: changed index takes effect on trigger unless overridden.
// - next mode, internal source, auto or armed auto: change switches after gap.
// - next mode, external: next trigger advances after gap; in auto, ordinary triggers ignored.
// - external advance past the last segment wraps to the first.
// - next mode, external, single: trigger replays once, next trigger advances.
// - sequencer, internal: step through play list order and repetitions automatically.
// - pass-through setting forwards embedded marker traces to marker outputs.
// - restart markers: marker 1 at sequence start, marker 2 each segment start.
// - option discards embedded markers, leaving only restart markers.
// - seamless auto: selection change applies at segment end without gap.
`timescale 1ns/1ps

// ***************************************************************
// sample fifo
// ***************************************************************
module msw_fifo #(
  parameter int W = 18,
  parameter int D = 4
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } msw_fifo_st_t;
  msw_fifo_st_t r;
  msw_fifo_st_t next_r;
  logic         push;
  logic         pop;

  assign in_ready  = r.cnt != FULL;
  assign out_valid = r.cnt != '0;
  assign out_data  = r.mem[r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = r.rp + 1'b1;
    end
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ***************************************************************
// playback controller
// ***************************************************************
module msw_play (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_pin,
  input  wire logic        next_pin,
  output logic [15:0]      sample_data,
  output logic             marker1,
  output logic             marker2,
  output logic             sample_valid,
  input  wire logic        sample_ready
);
  msw_pkg::msw_regs_t             r;
  msw_pkg::msw_regs_t             next_r;
  msw_pkg::msw_nmode_t            nm;
  msw_pkg::msw_tmode_t            tm;
  logic                           en;
  logic                           ext;
  logic                           armed;
  logic                           step;
  logic                           last;
  logic                           selchg;
  logic                           ev_trig;
  logic                           ev_next;
  logic                           apb_wr;
  logic [msw_pkg::OFS_W-1:0]      rd_addr;
  logic [msw_pkg::WORD_W-1:0]     push_word;
  logic                           fifo_out_valid;
  logic                           fifo_out_ready;
  logic [msw_pkg::WORD_W-1:0]     fifo_out_data;
  logic [msw_pkg::SEG_W-1:0]      lnext;

  assign nm      = msw_pkg::msw_nmode_t'(r.ctrl[msw_pkg::CTRL_NM +: 2]);
  assign tm      = msw_pkg::msw_tmode_t'(r.ctrl[msw_pkg::CTRL_TM +: 3]);
  assign en      = r.ctrl[msw_pkg::CTRL_EN];
  assign ext     = r.ctrl[msw_pkg::CTRL_EXT];
  assign armed   = tm == msw_pkg::TM_ARMED_AUTO || tm == msw_pkg::TM_ARMED_RETRIG;
  assign selchg  = r.sel != r.applied;
  assign last    = r.ofs == r.segt[r.cur][msw_pkg::SEG_LAST +: msw_pkg::OFS_W];
  assign rd_addr = r.segt[r.cur][msw_pkg::OFS_W-1:0] + r.ofs;
  assign lnext   = r.list[r.seq_idx][msw_pkg::LST_NXT +: msw_pkg::SEG_W];
  assign apb_wr  = psel && penable && r.pready && pwrite;
  // only the second and third sync stages feed the edge detect
  assign ev_trig = ext ? (r.trig_sync[1] && !r.trig_sync[2])
                       : (apb_wr && paddr == msw_pkg::REG_TRIG && pwdata[msw_pkg::TRIG_FIRE]);
  assign ev_next = ext && r.next_sync[1] && !r.next_sync[2];
  assign fifo_out_ready = !r.out_valid || sample_ready;

  assign prdata       = r.prdata;
  assign pready       = r.pready;
  assign pslverr      = r.pslverr;
  assign sample_data  = r.out_word[msw_pkg::SMP_W-1:0];
  assign marker1      = r.out_word[msw_pkg::MK1];
  assign marker2      = r.out_word[msw_pkg::MK2];
  assign sample_valid = r.out_valid;

  // the player always offers a word; a stalled sink holds the whole sequence
  msw_fifo #(.W(msw_pkg::WORD_W), .D(msw_pkg::FIFO_D)) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (1'b1),
    .in_ready  (step),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    logic [31:0] rd;
    logic        hit;
    logic [msw_pkg::WORD_W-1:0] w;
    rd = '0;
    hit = 1'b1;
    w = r.wave[rd_addr];
    next_r = r;
    push_word = '0;
    next_r.trig_sync = {r.trig_sync[1:0], trig_pin};
    next_r.next_sync = {r.next_sync[1:0], next_pin};
    // ***************************************************************
    // apb slave: no wait state, read data captured in setup
    // ***************************************************************
    if (paddr[7:4] == msw_pkg::PAGE_SEG) begin
      rd = 32'(r.segt[paddr[3:2]]);
    end else if (paddr[7:4] == msw_pkg::PAGE_LIST) begin
      rd = 32'(r.list[paddr[3:2]]);
    end else begin
      case (paddr)
        msw_pkg::REG_CTRL:  rd = 32'(r.ctrl);
        msw_pkg::REG_SEL:   rd = 32'(r.sel);
        msw_pkg::REG_TRIG:  rd = '0;
        msw_pkg::REG_STAT:  rd = {26'h0000000, r.seq_idx, r.st, r.cur};
        msw_pkg::REG_WADDR: rd = 32'(r.waddr);
        msw_pkg::REG_WDATA: rd = 32'(r.wave[r.waddr]);
        default:            hit = 1'b0;
      endcase
    end
    next_r.pready = psel && !penable && !r.pready;
    if (psel && !penable) begin
      next_r.prdata = pwrite ? 32'h00000000 : rd;
      next_r.pslverr = !hit;
    end
    if (apb_wr) begin
      if (paddr[7:4] == msw_pkg::PAGE_SEG) begin
        next_r.segt[paddr[3:2]] = pwdata[msw_pkg::SEGT_W-1:0];
      end else if (paddr[7:4] == msw_pkg::PAGE_LIST) begin
        next_r.list[paddr[3:2]] = pwdata[msw_pkg::LIST_W-1:0];
      end else if (paddr == msw_pkg::REG_CTRL) begin
        next_r.ctrl = pwdata[msw_pkg::CTRL_W-1:0];
      end else if (paddr == msw_pkg::REG_SEL) begin
        next_r.sel = pwdata[msw_pkg::SEG_W-1:0];
      end else if (paddr == msw_pkg::REG_WADDR) begin
        next_r.waddr = pwdata[msw_pkg::OFS_W-1:0];
      end else if (paddr == msw_pkg::REG_WDATA) begin
        next_r.wave[r.waddr] = pwdata[msw_pkg::WORD_W-1:0];
        next_r.waddr = r.waddr + 1'b1;
      end
    end
    // ***************************************************************
    // trigger capture: a new event wins over consumption
    // ***************************************************************
    next_r.pend_trig = (r.pend_trig && !step) || ev_trig;
    next_r.pend_next = (r.pend_next && !step) || ev_next;
    // ***************************************************************
    // player, advances only when the fifo accepts
    // ***************************************************************
    if (step && !en) begin
      next_r.st = msw_pkg::ST_HALT;
      next_r.cur = r.sel;
      next_r.applied = r.sel;
      next_r.seq_idx = '0;
    end else if (step) begin
      unique case (r.st)
        msw_pkg::ST_HALT: begin
          if ((!armed && tm != msw_pkg::TM_SINGLE) || r.pend_trig) begin
            next_r.st = msw_pkg::ST_PLAY;
            next_r.ofs = '0;
            next_r.first = 1'b1;
            next_r.once = tm == msw_pkg::TM_SINGLE;
            if (nm == msw_pkg::NM_SEQ) begin
              next_r.seq_idx = '0;
              next_r.cur = r.list[0][msw_pkg::SEG_W-1:0];
              next_r.reps = r.list[0][msw_pkg::LST_REP +: 4];
            end else if (selchg) begin
              next_r.cur = r.sel;
              next_r.applied = r.sel;
            end
          end
        end
        msw_pkg::ST_GAP: begin
          if (r.gap_cnt == '0) begin
            next_r.st = msw_pkg::ST_PLAY;
            next_r.ofs = '0;
          end else begin
            next_r.gap_cnt = r.gap_cnt - 1'b1;
          end
        end
        msw_pkg::ST_PLAY: begin
          push_word[msw_pkg::SMP_W-1:0] = w[msw_pkg::SMP_W-1:0];
          if (r.ctrl[msw_pkg::CTRL_RSTMK]) begin
            push_word[msw_pkg::MK1] = r.first && r.ofs == '0;
            push_word[msw_pkg::MK2] = r.ofs == '0;
          end else if (!r.ctrl[msw_pkg::CTRL_IGNMK]) begin
            push_word[msw_pkg::MK2:msw_pkg::MK1] = w[msw_pkg::MK2:msw_pkg::MK1];
          end
          next_r.first = 1'b0;
          next_r.ofs = r.ofs + 1'b1;
          if (last) begin
            next_r.ofs = '0;
            if (r.once) begin
              next_r.st = msw_pkg::ST_HALT;
            end else if (nm == msw_pkg::NM_SEQ) begin
              if (r.reps > 4'h1) begin
                next_r.reps = r.reps - 1'b1;
              end else begin
                next_r.seq_idx = lnext;
                next_r.cur = r.list[lnext][msw_pkg::SEG_W-1:0];
                next_r.reps = r.list[lnext][msw_pkg::LST_REP +: 4];
                next_r.first = lnext == '0;
              end
            end else if (nm == msw_pkg::NM_SEAMLESS && selchg) begin
              next_r.cur = r.sel;
              next_r.applied = r.sel;
            end
          end
        end
        default: next_r.st = msw_pkg::ST_HALT;
      endcase
      // segment change while running
      if (r.st != msw_pkg::ST_HALT && selchg && tm != msw_pkg::TM_SINGLE
          && (nm == msw_pkg::NM_SAME || nm == msw_pkg::NM_NEXT)) begin
        next_r.cur = r.sel;
        next_r.applied = r.sel;
        next_r.first = 1'b1;
        if (armed && !(nm == msw_pkg::NM_NEXT && !ext && tm == msw_pkg::TM_ARMED_AUTO)) begin
          next_r.st = msw_pkg::ST_HALT;
        end else begin
          next_r.st = msw_pkg::ST_GAP;
          next_r.gap_cnt = msw_pkg::GAP_LOAD;
        end
      end
      // restart on trigger; auto and armed auto ignore it while running
      if (r.st != msw_pkg::ST_HALT && r.pend_trig && nm != msw_pkg::NM_SEQ
          && (tm == msw_pkg::TM_RETRIG || tm == msw_pkg::TM_ARMED_RETRIG || tm == msw_pkg::TM_SINGLE)) begin
        next_r.st = msw_pkg::ST_PLAY;
        next_r.ofs = '0;
        next_r.first = 1'b1;
        next_r.once = tm == msw_pkg::TM_SINGLE;
        if (selchg) begin
          next_r.cur = r.sel;
          next_r.applied = r.sel;
        end
      end
      // external advance, natural 2-bit wrap from last to first
      if (r.pend_next && nm == msw_pkg::NM_NEXT && ext) begin
        next_r.cur = r.cur + 1'b1;
        next_r.st = msw_pkg::ST_GAP;
        next_r.gap_cnt = msw_pkg::GAP_LOAD;
        next_r.ofs = '0;
        next_r.first = 1'b1;
        next_r.once = tm == msw_pkg::TM_SINGLE;
      end
    end
    // ***************************************************************
    // registered output stage
    // ***************************************************************
    if (fifo_out_ready) begin
      next_r.out_valid = fifo_out_valid;
      next_r.out_word = fifo_out_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r <= msw_pkg::REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_run_same;
    en && step && nm == msw_pkg::NM_SAME && r.st == msw_pkg::ST_PLAY;
  endsequence
  sequence s_sel_switch;
    s_run_same ##0 selchg && !r.pend_trig;
  endsequence

  AST_IDLE_ZERO: assert property (step && r.st != msw_pkg::ST_PLAY |-> push_word == '0)
    else $error("non-zero word outside playback");
  AST_AUTO_START: assert property (en && step && r.st == msw_pkg::ST_HALT && tm == msw_pkg::TM_AUTO
    |=> r.st == msw_pkg::ST_PLAY && r.ofs == '0)
    else $error("auto did not start at once");
  AST_AUTO_IGNORE: assert property (s_run_same ##0 tm == msw_pkg::TM_AUTO && !selchg && !last
    |=> r.ofs == $past(r.ofs) + 1'b1)
    else $error("auto playback disturbed");
  AST_ARMED_WAIT: assert property (en && step && r.st == msw_pkg::ST_HALT && armed && !r.pend_trig
    |=> r.st == msw_pkg::ST_HALT)
    else $error("armed start without trigger");
  AST_SEL_GAP: assert property (s_sel_switch ##0 (tm == msw_pkg::TM_AUTO || tm == msw_pkg::TM_RETRIG)
    |=> r.st == msw_pkg::ST_GAP && r.cur == $past(r.sel) && r.gap_cnt == msw_pkg::GAP_LOAD)
    else $error("segment change did not enter gap");
  AST_SEL_HALT: assert property (s_sel_switch ##0 armed |=> r.st == msw_pkg::ST_HALT)
    else $error("armed segment change did not halt");
  AST_RETRIG: assert property (s_run_same ##0 r.pend_trig && tm == msw_pkg::TM_ARMED_RETRIG
    |=> r.ofs == '0 && r.st == msw_pkg::ST_PLAY)
    else $error("retrigger did not restart");
  AST_SINGLE_END: assert property (s_run_same ##0 r.once && last && !r.pend_trig
    |=> r.st == msw_pkg::ST_HALT)
    else $error("single pass did not stop");
  AST_SINGLE_KEEP: assert property (s_run_same ##0 tm == msw_pkg::TM_SINGLE && selchg && !r.pend_trig && !last
    |=> r.st == msw_pkg::ST_PLAY && r.cur == $past(r.cur))
    else $error("single interrupted by segment change");
  AST_WRAP: assert property (en && step && r.pend_next && ext && nm == msw_pkg::NM_NEXT && r.cur == 2'h3
    |=> r.cur == 2'h0 && r.st == msw_pkg::ST_GAP)
    else $error("advance did not wrap");
endmodule

// ### test/msw_far_model.sv
// far side of the player: trigger pulse source and a sample sink that can stall
`timescale 1ns/1ps

module msw_far_model #(
  parameter int PULSE = 4
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic fire_trig,
  input  wire logic fire_next,
  input  wire logic slow,
  output logic      trig_pin,
  output logic      next_pin,
  output logic      sample_ready
);
  logic [3:0] t_cnt;
  logic [3:0] n_cnt;
  logic [1:0] phase;

  // pins are held several cycles so the player's three-stage synchroniser sees each edge
  always_ff @(posedge clock) begin
    if (rst) begin
      t_cnt <= 4'h0;
      n_cnt <= 4'h0;
      phase <= 2'h0;
    end else begin
      t_cnt <= fire_trig ? 4'(PULSE) : (t_cnt != 4'h0 ? t_cnt - 4'h1 : 4'h0);
      n_cnt <= fire_next ? 4'(PULSE) : (n_cnt != 4'h0 ? n_cnt - 4'h1 : 4'h0);
      phase <= phase + 2'h1;
    end
  end

  assign trig_pin = (t_cnt != 4'h0);
  assign next_pin = (n_cnt != 4'h0);
  // a slow sink takes one word in four, so the player's stall path is exercised
  assign sample_ready = !slow || (phase == 2'h0);
endmodule

// ### test/tb.sv
// self-checking testbench of the playback controller
`timescale 1ns/1ps

module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig_pin;
  logic        next_pin;
  logic [15:0] sample_data;
  logic        marker1;
  logic        marker2;
  logic        sample_valid;
  logic        sample_ready;
  logic        fire_trig = 1'b0;
  logic        fire_next = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic        err;
  logic [17:0] w;
  logic [17:0] words[$];
  int          zrun;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #50 clock = ~clock;

  msw_play i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_pin(trig_pin), .next_pin(next_pin), .sample_data(sample_data), .marker1(marker1),
    .marker2(marker2), .sample_valid(sample_valid), .sample_ready(sample_ready));

  msw_far_model i_far (.clock(clock), .rst(rst), .fire_trig(fire_trig), .fire_next(fire_next),
    .slow(slow), .trig_pin(trig_pin), .next_pin(next_pin), .sample_ready(sample_ready));

  // every accepted word is kept, so nothing is lost while the bench is busy on the bus
  always @(posedge clock) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
      words.push_back({marker2, marker1, sample_data});
    end
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    $display("[FAIL] wait expected answer seen none");
    close_out();
  endtask

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic get_word();
    int n;
    n = 0;
    while (words.size() == 0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (words.size() == 0) timeout();
    w = words.pop_front();
  endtask

  // search for a whole word; zrun counts the zero words just before it
  task automatic find(logic [17:0] exp, int gap);
    int n;
    zrun = 0;
    n = 0;
    get_word();
    while (w !== exp && n < 400) begin
      zrun = (w === 18'h0) ? zrun + 1 : 0;
      get_word();
      n++;
    end
    check("word", 32'(exp), 32'(w));
    if (gap >= 0) check("gap words", gap, zrun);
  endtask

  task automatic next_word(logic [17:0] exp);
    get_word();
    check("next word", 32'(exp), 32'(w));
  endtask

  task automatic idle_check();
    repeat (12) get_word();
    repeat (3) next_word(18'h0);
  endtask

  task automatic pulse_next();
    @(posedge clock);
    fire_next <= 1'b1;
    @(posedge clock);
    fire_next <= 1'b0;
  endtask

  function automatic logic [17:0] wd(int s, int i);
    return {1'b0, (s == 2 && i == 0), 16'(32'hA000 + s * 256 + i)};
  endfunction

  function automatic logic [31:0] ct(logic [1:0] nm, logic [2:0] tm, logic ext, logic rm, logic ig);
    return {23'h0, ig, rm, ext, tm, nm, 1'b1};
  endfunction

  task automatic start(int sel, logic [31:0] c);
    apb(1'b1, msw_pkg::REG_CTRL, 32'h0);
    apb(1'b1, msw_pkg::REG_SEL, 32'(sel));
    words.delete();
    apb(1'b1, msw_pkg::REG_CTRL, c);
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, msw_pkg::REG_WADDR, 32'(8 * s));
      for (int i = 0; i < 2; i++) apb(1'b1, msw_pkg::REG_WDATA, 32'(wd(s, i)));
      apb(1'b1, 8'(32'h20 + 4 * s), 32'(32'h100 + 8 * s));
    end
    apb(1'b1, 8'h30, 32'h101);
    apb(1'b1, 8'h34, 32'h003);
    apb(1'b1, msw_pkg::REG_CTRL, 32'hFFFF_F1F0);
    apb(1'b0, msw_pkg::REG_CTRL, 32'h0);
    check("ctrl", 32'h1F0, rd);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    apb(1'b0, msw_pkg::REG_TRIG, 32'h0);
    check("trig read", 32'h0, rd);
    start(0, ct(msw_pkg::NM_SAME, msw_pkg::TM_AUTO, 1'b0, 1'b0, 1'b0));
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(wd(0, 0), -1);
    next_word(wd(0, 1));
    next_word(wd(0, 0));
    apb(1'b1, msw_pkg::REG_SEL, 32'h1);
    find(wd(1, 0), msw_pkg::GAP_CYC);
    start(0, ct(msw_pkg::NM_SAME, msw_pkg::TM_ARMED_AUTO, 1'b0, 1'b0, 1'b0));
    idle_check();
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(wd(0, 0), -1);
    apb(1'b1, msw_pkg::REG_SEL, 32'h1);
    idle_check();
    apb(1'b0, msw_pkg::REG_STAT, 32'h0);
    check("status", 32'h1, rd);
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(wd(1, 0), -1);
    start(1, ct(msw_pkg::NM_SAME, msw_pkg::TM_SINGLE, 1'b0, 1'b0, 1'b0));
    idle_check();
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(wd(1, 0), -1);
    next_word(wd(1, 1));
    next_word(18'h0);
    apb(1'b1, msw_pkg::REG_SEL, 32'h2);
    idle_check();
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(wd(2, 0), -1);
    slow <= 1'b1;
    start(2, ct(msw_pkg::NM_SAME, msw_pkg::TM_AUTO, 1'b0, 1'b1, 1'b1));
    find(18'h3A200, -1);
    next_word(18'h0A201);
    next_word(18'h2A200);
    slow <= 1'b0;
    start(0, ct(msw_pkg::NM_SAME, msw_pkg::TM_RETRIG, 1'b0, 1'b1, 1'b0));
    find(18'h3A000, -1);
    next_word(18'h0A001);
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(18'h3A000, -1);
    start(0, ct(msw_pkg::NM_SAME, msw_pkg::TM_ARMED_RETRIG, 1'b0, 1'b1, 1'b0));
    idle_check();
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(18'h3A000, -1);
    next_word(18'h0A001);
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(18'h3A000, -1);
    start(0, ct(msw_pkg::NM_NEXT, msw_pkg::TM_ARMED_AUTO, 1'b0, 1'b0, 1'b0));
    apb(1'b1, msw_pkg::REG_TRIG, 32'h1);
    find(wd(0, 0), -1);
    apb(1'b1, msw_pkg::REG_SEL, 32'h2);
    find(wd(2, 0), msw_pkg::GAP_CYC);
    start(0, ct(msw_pkg::NM_SEQ, msw_pkg::TM_AUTO, 1'b0, 1'b0, 1'b0));
    find(wd(1, 0), -1);
    next_word(wd(1, 1));
    next_word(wd(3, 0));
    next_word(wd(3, 1));
    next_word(wd(1, 0));
    start(3, ct(msw_pkg::NM_NEXT, msw_pkg::TM_AUTO, 1'b1, 1'b0, 1'b0));
    find(wd(3, 0), -1);
    pulse_next();
    find(wd(0, 0), msw_pkg::GAP_CYC);
    close_out();
  end
endmodule
